// ==== bench/rafe_host.sv ====
`timescale 1ns/1ps
// ==========================================================
// Remote host: sends queued request bytes, takes replies slowly
module rafe_host (
    // Clock
    input  wire logic       clk_sys,
    // Request stream
    output      logic       rx_valid,
    output      logic [7:0] rx_data,
    input  wire logic       rx_ready,
    // Reply stream
    output      logic       tx_ready
);
    logic [7:0] q[$];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    always @(posedge clk_sys) begin
        tx_ready <= ($urandom % 4) != 0;
        if (!rx_valid || rx_ready) begin
            rx_valid <= q.size() != 0;
            // Idle line toggles so a stale byte never looks valid
            rx_data  <= q.size() != 0 ? q.pop_front() : ~rx_data;
        end
    end
endmodule // rafe_host

// ==== bench/tb_register_access_frame_engine.sv ====
`timescale 1ns/1ps
module tb_register_access_frame_engine;
    import rafe_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        rx_valid, rx_ready, tx_valid, tx_ready;
    logic        reg_wr_en, reg_rd_en, session_close;
    rafe_byte_t  rx_data, tx_data;
    rafe_word_t  reg_wr_addr, reg_wr_data, reg_rd_addr;
    rafe_word_t  reg_rd_data = 16'h0000;
    logic [31:0] tq[$], wq[$];
    int          n_errors = 0, n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    rafe_engine #(.IDLE_CYCLES(50)) dut (.clk_sys, .rst, .rx_valid,
        .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .reg_wr_en,
        .reg_wr_addr, .reg_wr_data, .reg_rd_en, .reg_rd_addr, .reg_rd_data,
        .session_close);
    rafe_host host (.clk_sys, .rx_valid, .rx_data, .rx_ready, .tx_ready);
    // ==========================================================
    // Register file answers one cycle after the read strobe
    always @(posedge clk_sys)
        reg_rd_data <= reg_rd_en ? reg_rd_addr ^ 16'hC3A5 : $urandom;
    task automatic check(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) if (!rst) begin
        if (tx_valid && tx_ready)
            check(tx_data, tq.size() ? tq.pop_front() : 'x);
        if (reg_wr_en)
            check({reg_wr_addr, reg_wr_data},
                  wq.size() ? wq.pop_front() : 'x);
    end
    function automatic logic [31:0] crc(input logic [7:0] b[$],
        input int lo, hi, input logic [31:0] c, p);
        for (int i = lo; i <= hi; i++) begin
            c ^= {b[i], 24'h000000};
            repeat (8) c = c[31] ? (c << 1) ^ p : c << 1;
        end
        return c;
    endfunction
    task automatic make(ref logic [7:0] f[$], input logic [7:0] op, st,
        input logic [31:0] len, input logic [15:0] a, input logic fl,
        input logic [7:0] p[$], input int md, input bit req);
        logic [31:0] c;
        f = {8'hA1, 8'hEC, 8'h03, op};
        repeat (54) f.push_back(req ? $urandom : 8'h00);
        if (!req) f[5] = st;
        f[6] = 8'h00;
        f[7] = {7'h00, fl};
        {f[8], f[9], f[10], f[11], f[12], f[13]} = {len, a};
        c = p.size() ? crc(p, 0, p.size() - 1, 32'h0FFFFFFF,
                           32'h04C11DB7) : 32'h0;
        if (md == 1) c = ~c;
        f = {f, c[31:24], c[23:16], c[15:8], c[7:0]};
        c = crc(f, 2, 61, 32'h0, 32'h10210000);
        if (md == 2) c = ~c;
        f = {f, c[31:24], c[23:16], p};
    endtask
    task automatic run(input logic [7:0] op, input int len, md,
        input logic fl);
        logic [7:0] f[$], p[$], r[$], st;
        logic [15:0] a, v;
        int k;
        a = $urandom;
        if (op == 8'h04) repeat (len) p.push_back($urandom);
        st = md == 2 ? 8'h01 : len % 2 || len > 128 ? 8'h03
           : md == 1 && !fl ? 8'h02 : 8'h00;
        if (md == 3) host.q = {8'h55, 8'hA1};
        make(f, op, 8'h00, len, a, fl, p, md, 1'b1);
        host.q = {host.q, f};
        for (int i = 0; i < len / 2 && st == 8'h00; i++) begin
            v = a + 16'(i);
            if (op == 8'h04) wq.push_back({v, p[2*i], p[2*i+1]});
            else r = {r, v[15:8] ^ 8'hC3, v[7:0] ^ 8'hA5};
        end
        make(f, op, st, op == 8'h03 && st == 0 ? len : 0, a, 1'b0, r, 0,
             1'b0);
        foreach (f[i]) tq.push_back(f[i]);
        for (k = 0; k < 9000 && (host.q.size() || tq.size() || wq.size());
             k++) @(posedge clk_sys);
        if (k == 9000) begin
            n_errors++;
            stop_test();
        end
        $display("test op %h len %0d mode %0d done", op, len, md);
    endtask
    initial begin
        int k;
        void'($urandom(90077));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        run(8'h04, 4, 0, 1'b0);
        run(8'h03, 6, 0, 1'b0);
        run(8'h04, 2, 1, 1'b1);
        run(8'h04, 2, 1, 1'b0);
        run(8'h03, 4, 2, 1'b0);
        run(8'h04, 3, 0, 1'b0);
        run(8'h03, 130, 0, 1'b0);
        run(8'h04, 128, 3, 1'b0);
        for (k = 0; k < 200 && session_close !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        check(session_close, 1'b1);
        $display("test session close done");
        stop_test();
    end
endmodule // tb_register_access_frame_engine

// ==== hdl/rafe_engine.sv ====
`timescale 1ns/1ps
`include "rafe_consts.svh"
// Function
// - Frames start with marker A1 EC
// - Byte 0x02 carries revision 0x03
// - Read reply carries opcode 0x03
// - Read reply length is twice registers
// - Read reply echoes start address
// - Read payload words sent high first
// - Payload CRC-32 at offset 0x3A
// - Header CRC-CCITT at offset 0x3E
// - Flags bit 0 skips payload check
// - Write starts at address, then increments
// - Write reply: opcode, zero length, address
module rafe_engine
    import rafe_pkg::*;
#(
    parameter int          MAX_WORDS   = 64,
    parameter int          FIFO_DEPTH  = 4,
    parameter int unsigned IDLE_CYCLES =
        `RAFE_IDLE_TIME_MS * `RAFE_CLK_KHZ
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Request byte stream
    input  wire logic                  rx_valid,
    input  wire rafe_pkg::rafe_byte_t  rx_data,
    output      logic                  rx_ready,
    // Reply byte stream
    output      logic                  tx_valid,
    output      rafe_pkg::rafe_byte_t  tx_data,
    input  wire logic                  tx_ready,
    // Register port
    output      logic                  reg_wr_en,
    output      logic [15:0]           reg_wr_addr,
    output      rafe_pkg::rafe_word_t  reg_wr_data,
    output      logic                  reg_rd_en,
    output      logic [15:0]           reg_rd_addr,
    input  wire rafe_pkg::rafe_word_t  reg_rd_data,
    // Session
    output      logic                  session_close
);
    import rafe_pkg::*;

    localparam int          WW        = $clog2(MAX_WORDS);
    localparam logic [31:0] MAX_BYTES = 32'(2 * MAX_WORDS);

    // ==========================================================
    // Checksum and big-endian byte select helpers
    function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                               input logic [7:0]  b);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[31] ^ b[i]) ? ({r[30:0], 1'b0} ^ `RAFE_CRC32_POLY)
                               : {r[30:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0]  b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ `RAFE_CRC16_POLY)
                               : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic [7:0] be32(input logic [31:0] v,
                                        input logic [1:0]  k);
        return v[8*(3-k) +: 8];
    endfunction

    // ==========================================================
    // State
    rafe_state_e st_q, st_d;
    logic [6:0]  idx_q, idx_d;
    logic [31:0] len_q, len_d, rlen_q, rlen_d, cnt_q, cnt_d;
    logic [31:0] crc32_q, crc32_d, pcrc_q, pcrc_d;
    logic [15:0] crc16_q, crc16_d, hcrc_q, hcrc_d, addr_q, addr_d;
    logic [7:0]  op_q, op_d, status_q, status_d, hi_q, hi_d;
    logic        skip_q, skip_d, rev_ok_q, rev_ok_d, hok_q, hok_d;
    logic        wr_en_q, wr_en_d, rd_en_q, rd_en_d;
    logic [15:0] wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
    rafe_word_t  wr_data_q, wr_data_d;
    logic [31:0] idle_q, idle_d;
    logic        close_q, close_d;

    rafe_word_t  buf_q [MAX_WORDS];
    logic        buf_we;
    logic [WW-1:0] buf_wa;
    rafe_word_t  buf_wd;

    logic        rx_take, push, push_ready;
    rafe_byte_t  push_data;
    logic [1:0]  k_len, k_pcrc;
    logic        len_bad;

    assign rx_ready = (st_q == RAFE_S_HDR) || (st_q == RAFE_S_PAY);
    assign rx_take  = rx_valid && rx_ready;
    assign k_len    = 2'(idx_q - `RAFE_OFS_LEN_FIRST);
    assign k_pcrc   = 2'(idx_q - `RAFE_OFS_PCRC_FIRST);
    assign len_bad  = len_q[0] || (len_q > MAX_BYTES);

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;          idx_d = idx_q;       len_d = len_q;
        rlen_d = rlen_q;      cnt_d = cnt_q;       crc32_d = crc32_q;
        pcrc_d = pcrc_q;      crc16_d = crc16_q;   hcrc_d = hcrc_q;
        addr_d = addr_q;      op_d = op_q;         status_d = status_q;
        hi_d = hi_q;          skip_d = skip_q;     rev_ok_d = rev_ok_q;
        hok_d = hok_q;        wr_en_d = 1'b0;      rd_en_d = 1'b0;
        wr_addr_d = wr_addr_q; rd_addr_d = rd_addr_q;
        wr_data_d = wr_data_q;
        buf_we = 1'b0;        buf_wa = '0;         buf_wd = '0;
        push = 1'b0;          push_data = `RAFE_ZERO_BYTE;
        case (st_q)
            RAFE_S_HDR: begin
                if (rx_take) begin
                    idx_d = idx_q + 1'b1;
                    // Marker hunt restarts on any stray byte except an A1 after A1, which keeps it at the second byte
                    if (idx_q == `RAFE_OFS_PRE_HI) begin
                        if (rx_data != `RAFE_PRE_HI) idx_d = idx_q;
                    end else if (idx_q == `RAFE_OFS_PRE_LO) begin
                        if (rx_data != `RAFE_PRE_LO) begin
                            idx_d = (rx_data == `RAFE_PRE_HI) ? idx_q
                                                              : '0;
                        end
                    end
                    if (idx_q inside {[`RAFE_OFS_REV:`RAFE_OFS_PCRC_LAST]})
                    begin
                        crc16_d = crc16_byte(
                            (idx_q == `RAFE_OFS_REV) ? `RAFE_CRC16_INIT
                                                     : crc16_q,
                            rx_data);
                    end
                    if (idx_q == `RAFE_OFS_REV)
                        rev_ok_d = (rx_data == `RAFE_REVISION);
                    if (idx_q == `RAFE_OFS_OP) op_d = rx_data;
                    if (idx_q == `RAFE_OFS_FLAGS_LO)
                        skip_d = rx_data[`RAFE_FLAG_SKIP_BIT];
                    if (idx_q inside
                        {[`RAFE_OFS_LEN_FIRST:`RAFE_OFS_LEN_LAST]})
                        len_d = {len_q[23:0], rx_data};
                    if (idx_q inside {`RAFE_OFS_ADDR_HI, `RAFE_OFS_ADDR_LO})
                        addr_d = {addr_q[7:0], rx_data};
                    if (idx_q inside
                        {[`RAFE_OFS_PCRC_FIRST:`RAFE_OFS_PCRC_LAST]})
                        pcrc_d = {pcrc_q[23:0], rx_data};
                    if (idx_q inside {`RAFE_OFS_HCRC_HI, `RAFE_OFS_HCRC_LO})
                        hcrc_d = {hcrc_q[7:0], rx_data};
                    if (idx_q == `RAFE_OFS_HCRC_LO) begin
                        hok_d   = ({hcrc_q[7:0], rx_data} == crc16_q);
                        cnt_d   = '0;
                        crc32_d = `RAFE_CRC32_INIT;
                        st_d    = (hok_d && op_q == `RAFE_OP_WRITE &&
                                   len_q != '0) ? RAFE_S_PAY
                                                : RAFE_S_CHECK;
                    end
                end
            end
            RAFE_S_PAY: begin
                if (rx_take) begin
                    crc32_d = crc32_byte(crc32_q, rx_data);
                    cnt_d   = cnt_q + 1'b1;
                    if (!cnt_q[0]) begin
                        hi_d = rx_data;
                    end else if (cnt_q < MAX_BYTES) begin
                        buf_we = 1'b1;
                        buf_wa = cnt_q[WW:1];
                        buf_wd = {hi_q, rx_data};
                    end
                    if (cnt_d == len_q) st_d = RAFE_S_CHECK;
                end
            end
            RAFE_S_CHECK: begin
                idx_d    = '0;
                crc16_d  = `RAFE_CRC16_INIT;
                cnt_d    = '0;
                rlen_d   = '0;
                status_d = `RAFE_ST_OK;
                st_d     = RAFE_S_TX_HDR;
                if (!hok_q) begin
                    status_d = `RAFE_ST_HDR_CRC;
                end else if (!rev_ok_q) begin
                    status_d = `RAFE_ST_BAD_REV;
                end else if (op_q == `RAFE_OP_WRITE) begin
                    if (len_bad) begin
                        status_d = `RAFE_ST_BAD_LEN;
                    end else if (!skip_q && crc32_q != pcrc_q) begin
                        status_d = `RAFE_ST_PAY_CRC;
                    end else if (len_q != '0) begin
                        st_d = RAFE_S_WR;
                    end
                end else if (op_q == `RAFE_OP_READ) begin
                    crc32_d = `RAFE_CRC32_INIT;
                    if (len_bad) begin
                        status_d = `RAFE_ST_BAD_LEN;
                    end else if (len_q != '0) begin
                        rlen_d = len_q;
                        st_d   = RAFE_S_RD_REQ;
                    end
                end else begin
                    status_d = `RAFE_ST_BAD_OP;
                end
            end
            RAFE_S_WR: begin
                wr_en_d   = 1'b1;
                wr_addr_d = addr_q + cnt_q[15:0];
                wr_data_d = buf_q[cnt_q[WW-1:0]];
                cnt_d     = cnt_q + 1'b1;
                if (cnt_d == {1'b0, len_q[31:1]}) st_d = RAFE_S_TX_HDR;
            end
            RAFE_S_RD_REQ: begin
                rd_en_d   = 1'b1;
                rd_addr_d = addr_q + cnt_q[15:0];
                st_d      = RAFE_S_RD_WT;
            end
            RAFE_S_RD_WT: begin
                st_d = RAFE_S_RD_CAP;
            end
            RAFE_S_RD_CAP: begin
                buf_we  = 1'b1;
                buf_wa  = cnt_q[WW-1:0];
                buf_wd  = reg_rd_data;
                crc32_d = crc32_byte(crc32_byte(crc32_q, reg_rd_data[15:8]),
                                     reg_rd_data[7:0]);
                cnt_d   = cnt_q + 1'b1;
                st_d    = (cnt_d == {1'b0, rlen_q[31:1]}) ? RAFE_S_TX_HDR
                                                          : RAFE_S_RD_REQ;
            end
            RAFE_S_TX_HDR: begin
                push = 1'b1;
                case (idx_q)
                    `RAFE_OFS_PRE_HI: push_data = `RAFE_PRE_HI;
                    `RAFE_OFS_PRE_LO: push_data = `RAFE_PRE_LO;
                    `RAFE_OFS_REV:    push_data = `RAFE_REVISION;
                    `RAFE_OFS_OP:     push_data = op_q;
                    `RAFE_OFS_STATUS: push_data = status_q;
                    `RAFE_OFS_ADDR_HI: push_data = addr_q[15:8];
                    `RAFE_OFS_ADDR_LO: push_data = addr_q[7:0];
                    `RAFE_OFS_HCRC_HI: push_data = crc16_q[15:8];
                    `RAFE_OFS_HCRC_LO: push_data = crc16_q[7:0];
                    default: begin
                        if (idx_q inside
                            {[`RAFE_OFS_LEN_FIRST:`RAFE_OFS_LEN_LAST]})
                            push_data = be32(rlen_q, k_len);
                        else if (idx_q inside
                            {[`RAFE_OFS_PCRC_FIRST:`RAFE_OFS_PCRC_LAST]})
                            push_data = (rlen_q != '0) ?
                                be32(crc32_q, k_pcrc) : `RAFE_ZERO_BYTE;
                        else
                            push_data = `RAFE_ZERO_BYTE;
                    end
                endcase
                if (push_ready) begin
                    idx_d = idx_q + 1'b1;
                    if (idx_q inside
                        {[`RAFE_OFS_REV:`RAFE_OFS_PCRC_LAST]})
                        crc16_d = crc16_byte(crc16_q, push_data);
                    if (idx_q == `RAFE_OFS_HCRC_LO) begin
                        idx_d = '0;
                        cnt_d = '0;
                        st_d  = (rlen_q != '0) ? RAFE_S_TX_PAY : RAFE_S_HDR;
                    end
                end
            end
            RAFE_S_TX_PAY: begin
                push      = 1'b1;
                push_data = cnt_q[0] ? buf_q[cnt_q[WW:1]][7:0]
                                     : buf_q[cnt_q[WW:1]][15:8];
                if (push_ready) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_d == rlen_q) st_d = RAFE_S_HDR;
                end
            end
            default: begin
                st_d  = RAFE_S_HDR;
                idx_d = '0;
            end
        endcase
    end

    // Inactivity timer, restarted by every request byte
    always_comb begin
        idle_d  = idle_q + 1'b1;
        close_d = 1'b0;
        if (rx_take || st_q != RAFE_S_HDR) begin
            idle_d = '0;
        end else if (idle_q == IDLE_CYCLES - 1) begin
            idle_d  = '0;
            close_d = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= RAFE_S_HDR;  idx_q <= '0;     len_q <= '0;
            rlen_q <= '0;        cnt_q <= '0;     crc32_q <= '0;
            pcrc_q <= '0;        crc16_q <= '0;   hcrc_q <= '0;
            addr_q <= '0;        op_q <= '0;      status_q <= '0;
            hi_q <= '0;          skip_q <= 1'b0;  rev_ok_q <= 1'b0;
            hok_q <= 1'b0;       wr_en_q <= 1'b0; rd_en_q <= 1'b0;
            wr_addr_q <= '0;     rd_addr_q <= '0; wr_data_q <= '0;
            idle_q <= '0;        close_q <= 1'b0;
        end else begin
            st_q <= st_d;        idx_q <= idx_d;  len_q <= len_d;
            rlen_q <= rlen_d;    cnt_q <= cnt_d;  crc32_q <= crc32_d;
            pcrc_q <= pcrc_d;    crc16_q <= crc16_d; hcrc_q <= hcrc_d;
            addr_q <= addr_d;    op_q <= op_d;    status_q <= status_d;
            hi_q <= hi_d;        skip_q <= skip_d; rev_ok_q <= rev_ok_d;
            hok_q <= hok_d;      wr_en_q <= wr_en_d; rd_en_q <= rd_en_d;
            wr_addr_q <= wr_addr_d; rd_addr_q <= rd_addr_d;
            wr_data_q <= wr_data_d;
            idle_q <= idle_d;    close_q <= close_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (buf_we) begin
            buf_q[buf_wa] <= buf_wd;
        end
    end

    assign reg_wr_en     = wr_en_q;
    assign reg_wr_addr   = wr_addr_q;
    assign reg_wr_data   = wr_data_q;
    assign reg_rd_en     = rd_en_q;
    assign reg_rd_addr   = rd_addr_q;
    assign session_close = close_q;

    // ==========================================================
    // Reply buffer
    rafe_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (push),
        .in_data   (push_data),
        .in_ready  (push_ready),
        .out_valid (tx_valid),
        .out_data  (tx_data),
        .out_ready (tx_ready)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic tx_hdr_push;
    assign tx_hdr_push = (st_q == RAFE_S_TX_HDR) && push_ready;

    property p_marker;
        tx_hdr_push && idx_q == `RAFE_OFS_PRE_HI |->
            push_data == `RAFE_PRE_HI
            ##1 (st_q == RAFE_S_TX_HDR && idx_q == `RAFE_OFS_PRE_LO &&
                 push_data == `RAFE_PRE_LO);
    endproperty
    a_marker: assert property (p_marker) else $error("bad marker");

    property p_revision;
        tx_hdr_push && idx_q == `RAFE_OFS_REV |->
            push_data == `RAFE_REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("bad rev");

    property p_read_op;
        tx_hdr_push && idx_q == `RAFE_OFS_OP && rlen_q != '0 |->
            push_data == `RAFE_OP_READ;
    endproperty
    a_read_op: assert property (p_read_op) else $error("read op");

    property p_rd_len;
        st_q == RAFE_S_CHECK && hok_q && rev_ok_q &&
        op_q == `RAFE_OP_READ && !len_bad && len_q != '0 |=>
            rlen_q == len_q && !rlen_q[0] ##1 rd_en_q;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read len");

    property p_wr_step;
        wr_en_q && $past(wr_en_q) |->
            wr_addr_q == $past(wr_addr_q) + 16'h0001;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("addr step");

    property p_wr_reply;
        tx_hdr_push && op_q == `RAFE_OP_WRITE &&
        idx_q inside {[`RAFE_OFS_LEN_FIRST:`RAFE_OFS_LEN_LAST]} |->
            push_data == `RAFE_ZERO_BYTE;
    endproperty
    a_wr_reply: assert property (p_wr_reply) else $error("wr len");

    property p_no_err_write;
        wr_en_q |-> status_q == `RAFE_ST_OK && hok_q;
    endproperty
    a_no_err_write: assert property (p_no_err_write)
        else $error("write on error");

    property p_spare_zero;
        tx_hdr_push &&
        idx_q inside {[`RAFE_OFS_RSV_FIRST:`RAFE_OFS_RSV_LAST]} |->
            push_data == `RAFE_ZERO_BYTE;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare");

    property p_hcrc;
        tx_hdr_push && idx_q == `RAFE_OFS_HCRC_HI |->
            push_data == crc16_q[15:8];
    endproperty
    a_hcrc: assert property (p_hcrc) else $error("hdr crc");

    property p_skip;
        st_q == RAFE_S_CHECK && skip_q && hok_q |=>
            status_q != `RAFE_ST_PAY_CRC;
    endproperty
    a_skip: assert property (p_skip) else $error("skip flag");

    c_read: cover property (st_q == RAFE_S_TX_PAY ##1 st_q == RAFE_S_HDR);
    c_write: cover property (wr_en_q ##1 st_q == RAFE_S_TX_HDR);
    c_hdr_err: cover property (status_q == `RAFE_ST_HDR_CRC && tx_hdr_push);
    c_close: cover property (close_q);
endmodule // rafe_engine

// ==== hdl/rafe_fifo.sv ====
`timescale 1ns/1ps
module rafe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             in_ready,
    // Drain side
    output      logic             out_valid,
    output      logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule // rafe_fifo

// ==== inc/rafe_consts.svh ====
`ifndef RAFE_CONSTS_SVH
`define RAFE_CONSTS_SVH

// ==========================================================
// Frame constants
`define RAFE_PRE_HI        8'hA1
`define RAFE_PRE_LO        8'hEC
`define RAFE_REVISION      8'h03
`define RAFE_OP_READ       8'h03
`define RAFE_OP_WRITE      8'h04
`define RAFE_ZERO_BYTE     8'h00

// ==========================================================
// Header byte offsets
`define RAFE_OFS_PRE_HI    7'h00
`define RAFE_OFS_PRE_LO    7'h01
`define RAFE_OFS_REV       7'h02
`define RAFE_OFS_OP        7'h03
`define RAFE_OFS_STATUS    7'h05
`define RAFE_OFS_FLAGS_LO  7'h07
`define RAFE_OFS_LEN_FIRST 7'h08
`define RAFE_OFS_LEN_LAST  7'h0B
`define RAFE_OFS_ADDR_HI   7'h0C
`define RAFE_OFS_ADDR_LO   7'h0D
`define RAFE_OFS_RSV_FIRST 7'h0E
`define RAFE_OFS_RSV_LAST  7'h39
`define RAFE_OFS_PCRC_FIRST 7'h3A
`define RAFE_OFS_PCRC_LAST 7'h3D
`define RAFE_OFS_HCRC_HI   7'h3E
`define RAFE_OFS_HCRC_LO   7'h3F
`define RAFE_FLAG_SKIP_BIT 0

// ==========================================================
// Checksums
`define RAFE_CRC32_POLY    32'h04C11DB7
`define RAFE_CRC32_INIT    32'h0FFFFFFF
`define RAFE_CRC16_POLY    16'h1021
`define RAFE_CRC16_INIT    16'h0000

// ==========================================================
// Result codes
`define RAFE_ST_OK         8'h00
`define RAFE_ST_HDR_CRC    8'h01
`define RAFE_ST_PAY_CRC    8'h02
`define RAFE_ST_BAD_LEN    8'h03
`define RAFE_ST_BAD_REV    8'h04
`define RAFE_ST_BAD_OP     8'h05

// ==========================================================
// Timing
`define RAFE_IDLE_TIME_MS  2000
`define RAFE_CLK_KHZ       100000

`endif

// ==== inc/rafe_pkg.sv ====
package rafe_pkg;
    typedef logic [7:0] rafe_byte_t;
    typedef logic [15:0] rafe_word_t;
    typedef enum logic [3:0] {
        RAFE_S_HDR    = 4'h0,
        RAFE_S_PAY    = 4'h1,
        RAFE_S_CHECK  = 4'h2,
        RAFE_S_WR     = 4'h3,
        RAFE_S_RD_REQ = 4'h4,
        RAFE_S_RD_WT  = 4'h5,
        RAFE_S_RD_CAP = 4'h6,
        RAFE_S_TX_HDR = 4'h7,
        RAFE_S_TX_PAY = 4'h8
    } rafe_state_e;
endpackage
